//--- bench/afdc_sink.sv
// Purpose: Downstream serial port model taking corrected words
// Assumes: Ready changes only at the falling edge
// Notes:   Drops ready one cycle in three; stall holds it low
`timescale 1ns/10ps

module afdc_sink (
  // Clock and control
  input  wire logic i_sys_clk,
  input  wire logic i_stall,
  // Handshake
  output logic      o_out_ready
);
  int cyc;

  initial
  begin
    cyc = 0;
    o_out_ready = 1'b0;
    forever
    begin
      @(negedge i_sys_clk);
      cyc++;
      o_out_ready = !i_stall && (cyc % 3 != 0);
    end
  end
endmodule : afdc_sink

//--- bench/afdc_top_assertions.sv
// Purpose: Port checker for afdc_top
// Assumes: Single clock, synchronous active-high reset
// Notes:   Bound to afdc_top below the module
`timescale 1ns/10ps

module afdc_top_chk #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic                 i_sys_clk,
  input wire logic                 i_rst,
  // Configuration and streams
  input wire afdc_pkg::afdc_cfg_t  i_cfg,
  input wire logic                 i_in_valid,
  input wire afdc_pkg::afdc_quad_t i_in_data,
  input wire logic                 o_in_ready,
  input wire logic                 o_out_valid,
  input wire afdc_pkg::afdc_quad_t o_out_data,
  input wire logic                 i_out_ready
);
  logic [5:0]           fly_r;
  logic                 cap_r;
  logic                 seen_r;
  afdc_pkg::afdc_quad_t first_r;
  wire                  take = i_in_valid && o_in_ready;
  wire                  give = o_out_valid && i_out_ready;

  default clocking @(posedge i_sys_clk); endclocking

  // Words taken but not yet handed on
  always_ff @(posedge i_sys_clk)
    fly_r <= i_rst ? 6'h00 : fly_r + 6'(take) - 6'(give);

  always_ff @(posedge i_sys_clk)
    cap_r <= i_rst ? 1'b0 : (cap_r || take);

  always_ff @(posedge i_sys_clk)
    if (take && !cap_r)
      first_r <= i_in_data;

  always_ff @(posedge i_sys_clk)
    seen_r <= i_rst ? 1'b0 : (seen_r || give);

  sequence s_stall;
    o_out_valid && !i_out_ready;
  endsequence

  sequence s_take;
    i_in_valid && o_in_ready;
  endsequence

  chk_out_hold: assert property (disable iff (i_rst)
    s_stall |=> o_out_valid && $stable(o_out_data)) else $error("output changed while stalled");
  chk_answer_time: assert property (disable iff (i_rst)
    s_take |-> ##[1:200] o_out_valid) else $error("taken sample never answered");
  chk_rst_idle: assert property (i_rst |=> !o_out_valid && o_out_data == '0)
    else $error("output busy after reset");
  chk_rst_ready: assert property (i_rst |=> o_in_ready)
    else $error("input not ready after reset");
  chk_out_paired: assert property (disable iff (i_rst) o_out_valid |-> fly_r != 6'h00)
    else $error("output without a taken input");
  chk_refuse_full: assert property (disable iff (i_rst) !o_in_ready |-> fly_r >= FIFO_DEPTH)
    else $error("input refused before buffer full");
  chk_fly_bound: assert property (disable iff (i_rst) fly_r <= FIFO_DEPTH + 1)
    else $error("more words held than buffer space");
  chk_first_pass: assert property (disable iff (i_rst)
    o_out_valid && !seen_r |-> o_out_data == first_r) else $error("first word altered");
endmodule : afdc_top_chk

bind afdc_top afdc_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_afdc_top_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg(i_cfg), .i_in_valid(i_in_valid),
  .i_in_data(i_in_data), .o_in_ready(o_in_ready), .o_out_valid(o_out_valid),
  .o_out_data(o_out_data), .i_out_ready(i_out_ready));

//--- bench/tb.sv
// Purpose: Self-checking bench for afdc_top
// Assumes: Each scenario starts from reset
// Notes:   Inputs change at the falling edge
`timescale 1ns/10ps

module tb;
  localparam int FD = 16;
  logic                 clk;
  logic                 rst;
  afdc_pkg::afdc_cfg_t  cfg;
  logic                 in_valid;
  afdc_pkg::afdc_quad_t in_data;
  logic                 in_ready;
  logic                 out_valid;
  afdc_pkg::afdc_quad_t out_data;
  logic                 out_ready;
  logic                 stall;
  int                   bad_count;
  int                   cmp_count;
  int                   full_at;

  afdc_top #(.FIFO_DEPTH(FD)) i_afdc_top (.i_sys_clk(clk), .i_rst(rst), .i_cfg(cfg),
    .i_in_valid(in_valid), .i_in_data(in_data), .o_in_ready(in_ready),
    .o_out_valid(out_valid), .o_out_data(out_data), .i_out_ready(out_ready));
  afdc_sink i_afdc_sink (.i_sys_clk(clk), .i_stall(stall), .o_out_ready(out_ready));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk_smp(input string n, input afdc_pkg::afdc_smp_t e, g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk_smp

  task automatic chk_cnt(input string n, input int e, g);
    cmp_count++;
    if (g != e)
    begin
      bad_count++;
      $display("wrong value %s exp %0d got %0d", n, e, g);
    end
  endtask : chk_cnt

  function automatic afdc_pkg::afdc_smp_t sat(input longint v);
    if (v > 8388607)
      return 24'h7fffff;
    if (v < -8388608)
      return 24'h800000;
    return v[23:0];
  endfunction : sat

  // Per-scenario sample patterns, lane p of sample i
  function automatic longint dat(input int k, i, p);
    longint s;
    s = (p % 2) ? -1 : 1;
    case (k)
      0: return (p + 1) * 1000 + s * i * 37;
      1: return ((i < 2) ^ (p % 2)) ? 8388607 : -8388608;
      2: return s * (8 + (i + p) % 8);
      3: return (i == 4 || i == 5) ? 4194304 + p : (p + 1) * 50 + i;
      default: return i * 3 - p;
    endcase
  endfunction : dat

  task automatic push(input int i, k);
    logic                 r;
    afdc_pkg::afdc_quad_t d;
    for (int p = 0; p < 4; p++)
      d[(3 - p) * 24 +: 24] = 24'(dat(k, i, p));
    in_data = d;
    in_valid = 1'b1;
    for (int t = 0; t < 300; t++)
    begin
      r = in_ready;
      @(negedge clk);
      if (r === 1'b1)
        return;
      if (full_at < 0)
        full_at = i;
    end
    bad_count++;
    test_done;
  endtask : push

  task automatic wait_out;
    for (int t = 0; t < 300; t++)
    begin
      @(negedge clk);
      #1;
      if (out_valid === 1'b1 && out_ready === 1'b1)
        return;
    end
    bad_count++;
    test_done;
  endtask : wait_out

  // Streams n samples and checks each against the averaging reference
  task automatic run(input int m, u, l, e, k, n, input logic slow);
    longint est [4];
    longint acc [4];
    longint x;
    int     j;
    int     st;
    logic   ld;
    est = '{4{0}};
    acc = '{4{0}};
    j = 0;
    st = 0;
    @(negedge clk);
    cfg = {5'(m), 5'(u), 5'(l)};
    stall = slow;
    full_at = -1;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    fork
      begin
        for (int i = 0; i < n; i++)
          push(i, k);
        in_valid = 1'b0;
      end
      if (slow)
      begin
        repeat (60) @(negedge clk);
        stall = 1'b0;
      end
      for (int i = 0; i < n; i++)
      begin
        wait_out;
        ld = (k == 3 && (i == 4 || i == 5));
        for (int p = 0; p < 4; p++)
        begin
          x = dat(k, i, p);
          chk_smp("lane", sat(x - est[p]), out_data[(3 - p) * 24 +: 24]);
          if (ld)
            acc[p] = acc[p];
          else if (st != 1 || j == (1 << e))
          begin
            if (st == 1)
              est[p] = acc[p] >>> e;
            acc[p] = x;
          end
          else
            acc[p] += x;
        end
        if (ld)
          st = 2;
        else if (st != 1 || j == (1 << e))
        begin
          st = 1;
          j = 1;
        end
        else
          j++;
      end
    join
  endtask : run

  task automatic t_avg;
    run(2, 0, 0, 2, 0, 24, 1'b0);
  endtask : t_avg

  task automatic t_sat;
    run(1, 0, 0, 1, 1, 6, 1'b0);
  endtask : t_sat

  task automatic t_grow;
    run(1, 0, 20, 3, 2, 24, 1'b0);
  endtask : t_grow

  task automatic t_hold;
    run(1, 2, 0, 1, 3, 12, 1'b0);
  endtask : t_hold

  task automatic t_fill;
    run(5, 0, 0, 5, 4, 20, 1'b1);
    chk_cnt("taken before full", FD + 1, full_at);
  endtask : t_fill

  initial
  begin
    rst = 1'b1;
    cfg = '0;
    in_valid = 1'b0;
    in_data = '0;
    stall = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    t_avg;
    t_sat;
    t_grow;
    t_hold;
    t_fill;
    test_done;
  end
endmodule : tb

//--- hw/afdc_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Ready on the fill side is a registered not-full flag
`timescale 1ns/10ps

module afdc_fifo #(
  parameter int W     = 96,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_r;
  logic [AW:0]  rd_ptr_r;
  logic [AW:0]  wr_nxt;
  logic [AW:0]  rd_nxt;
  logic         in_ready_r;
  logic         push;
  logic         pop;
  logic         full;

  assign full        = !in_ready_r;
  assign o_out_valid = (wr_ptr_r != rd_ptr_r);
  assign o_in_ready  = in_ready_r;
  assign push        = i_in_valid && !full;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr_r[AW-1:0]];
  assign wr_nxt      = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
  assign rd_nxt      = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      in_ready_r <= 1'b1;
    end
    else
    begin
      wr_ptr_r   <= wr_nxt;
      rd_ptr_r   <= rd_nxt;
      // Full once the next pointers differ only in the wrap bit
      in_ready_r <= !((wr_nxt[AW] != rd_nxt[AW]) &&
                      (wr_nxt[AW-1:0] == rd_nxt[AW-1:0]));
    end
  end

endmodule : afdc_fifo

//--- hw/afdc_pkg.sv
// Purpose: Types for the adaptive fine dc correction block
// Assumes: afdc_regs.svh holds the constants
// Notes:   Nothing here is imported; use afdc_pkg::name
`include "afdc_regs.svh"

package afdc_pkg;

  typedef logic signed [`AFDC_SMP_W-1:0] afdc_smp_t;
  typedef logic        [`AFDC_MAG_W-1:0] afdc_mag_t;
  typedef logic        [`AFDC_EXP_W-1:0] afdc_exp_t;
  typedef logic        [`AFDC_LVL_W-1:0] afdc_lvl_t;

  // One sample strobe carries all four receive paths
  typedef struct packed {
    afdc_smp_t chan_a_inphase_path;
    afdc_smp_t chan_a_quadrature_path;
    afdc_smp_t chan_b_inphase_path;
    afdc_smp_t chan_b_quadrature_path;
  } afdc_quad_t;

  // Levels count 6 dB steps below full scale; smaller is louder
  typedef struct packed {
    afdc_exp_t min_period;
    afdc_lvl_t upper_thr;
    afdc_lvl_t lower_thr;
  } afdc_cfg_t;

  typedef enum logic [1:0] {
    AFDC_ST_START = 2'h0,
    AFDC_ST_RUN   = 2'h1,
    AFDC_ST_HOLD  = 2'h3
  } afdc_state_t;

endpackage : afdc_pkg

//--- hw/afdc_regs.svh
// Purpose: Constants for the adaptive fine dc correction block
// Assumes: Included by bare name from package and modules
// Notes:   Definitions only
//
// Functional notes
// - Each path averages samples into a dc estimate and subtracts it from every sample.
// - The dc subtraction saturates at the 24-bit output limits, never wraps.
// - Four paths keep fully separate peak, accumulator, subtractor and counter.
// - First sample loads peak with its magnitude and counter with minimum period.
// - Every sample replaces the held peak when its magnitude is larger.
// - Held peak is encoded as a level word in 6 dB steps below full scale.
// - Below lower threshold the counter cycles at the minimum period.
// - At counter zero: store estimate, load accumulator with sample, peak with magnitude.
// - The accumulator takes the 24-bit signed samples: the first after reset at any level, later ones except those above the upper threshold.
// - Above upper threshold the counter stays at minimum period; resumes when below.
// - Above upper threshold the partial sum is dropped, old estimate kept.
// - Between thresholds each 6 dB level rise makes the period four times longer.
// - Period is two to the minimum plus twice the steps above lower threshold.
`ifndef AFDC_REGS_SVH
`define AFDC_REGS_SVH

// ****************************************************************
// Widths and counts
// ****************************************************************
`define AFDC_SMP_W      24
`define AFDC_MAG_W      23
`define AFDC_EXP_W      5
`define AFDC_LVL_W      5
`define AFDC_EXP_MAX    20
`define AFDC_NPATH      4
`define AFDC_FIFO_DEPTH 16

// ****************************************************************
// Reset values
// ****************************************************************
`define AFDC_EST_RST    24'h000000
`define AFDC_PEAK_RST   23'h000000

`endif

//--- hw/afdc_top.sv
// Purpose: Adaptive fine dc offset correction for four receive paths
// Assumes: One sample strobe carries all four paths; single clock
// Notes:   Thresholds and minimum period come in as plain inputs
//          Input ready comes from the FIFO's registered not-full flag
`timescale 1ns/10ps
`include "afdc_regs.svh"

module afdc_top #(
  parameter int FIFO_DEPTH = `AFDC_FIFO_DEPTH,
  parameter int EXP_MAX    = `AFDC_EXP_MAX
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // Configuration
  input  wire afdc_pkg::afdc_cfg_t i_cfg,
  // Samples from the channel filter
  input  wire logic             i_in_valid,
  input  wire afdc_pkg::afdc_quad_t i_in_data,
  output logic                  o_in_ready,
  // Corrected samples to the serial port
  output logic                  o_out_valid,
  output afdc_pkg::afdc_quad_t  o_out_data,
  input  wire logic             i_out_ready
);

  localparam int SW    = `AFDC_SMP_W;
  localparam int MW    = `AFDC_MAG_W;
  localparam int ACC_W = SW + EXP_MAX;
  localparam int CNT_W = EXP_MAX + 1;
  localparam int NP    = `AFDC_NPATH;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Rectify with the negative limit folded onto the positive one
  function automatic afdc_pkg::afdc_mag_t f_mag(input afdc_pkg::afdc_smp_t x);
    logic [SW-1:0] neg;
    neg = -x;
    if (!x[SW-1])
    begin
      f_mag = x[MW-1:0];
    end
    else if (neg[SW-1])
    begin
      f_mag = {MW{1'b1}};
    end
    else
    begin
      f_mag = neg[MW-1:0];
    end
  endfunction : f_mag

  // Leading zeros of the magnitude: 6 dB steps below full scale
  function automatic afdc_pkg::afdc_lvl_t f_lvl(input afdc_pkg::afdc_mag_t m);
    logic done;
    f_lvl = afdc_pkg::afdc_lvl_t'(MW);
    done  = 1'b0;
    for (int i = MW - 1; i >= 0; i--)
    begin
      if (m[i] && !done)
      begin
        f_lvl = afdc_pkg::afdc_lvl_t'(MW - 1 - i);
        done  = 1'b1;
      end
    end
  endfunction : f_lvl

  // Period exponent clamped to what the accumulator can hold
  function automatic afdc_pkg::afdc_exp_t f_clamp(input logic [6:0] e);
    if (e > 7'(EXP_MAX))
    begin
      f_clamp = afdc_pkg::afdc_exp_t'(EXP_MAX);
    end
    else
    begin
      f_clamp = e[`AFDC_EXP_W-1:0];
    end
  endfunction : f_clamp

  function automatic logic [CNT_W-1:0] f_pow2(input afdc_pkg::afdc_exp_t e);
    f_pow2 = CNT_W'(1) << e;
  endfunction : f_pow2

  // Counter reload: zero marks the sample that closes a period and starts the next sum
  function automatic logic [CNT_W-1:0] f_reload(input afdc_pkg::afdc_exp_t e);
    f_reload = f_pow2(e) - 1'b1;
  endfunction : f_reload

  // Subtract with saturation at the sample limits
  function automatic afdc_pkg::afdc_smp_t f_sat_sub(
    input afdc_pkg::afdc_smp_t a,
    input afdc_pkg::afdc_smp_t b
  );
    logic signed [SW:0] d;
    d = {a[SW-1], a} - {b[SW-1], b};
    if (d[SW] != d[SW-1])
    begin
      f_sat_sub = d[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
    end
    else
    begin
      f_sat_sub = d[SW-1:0];
    end
  endfunction : f_sat_sub

  // ****************************************************************
  // Input FIFO and stream handshake
  // ****************************************************************
  afdc_pkg::afdc_quad_t             fifo_data;
  logic                             fifo_valid;
  logic                             take;
  afdc_pkg::afdc_smp_t [NP-1:0]     smp;
  afdc_pkg::afdc_smp_t [NP-1:0]     out_r;
  logic                             out_valid_r;
  afdc_pkg::afdc_exp_t              min_exp;

  // Pop only when the output register is free or being drained
  assign take    = fifo_valid && (!out_valid_r || i_out_ready);
  assign smp     = fifo_data;
  assign min_exp = f_clamp({2'h0, i_cfg.min_period});

  afdc_fifo #(
    .W     ($bits(afdc_pkg::afdc_quad_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_in_valid),
    .i_in_data   (i_in_data),
    .o_in_ready  (o_in_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (take)
  );

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      out_valid_r <= 1'b0;
    end
    else if (take)
    begin
      out_valid_r <= 1'b1;
    end
    else if (i_out_ready)
    begin
      out_valid_r <= 1'b0;
    end
  end

  assign o_out_valid = out_valid_r;
  assign o_out_data  = out_r;

  // ****************************************************************
  // Per-path correction
  // ****************************************************************
  for (genvar p = 0; p < NP; p++)
  begin : g_path
    afdc_pkg::afdc_state_t  st_r;
    afdc_pkg::afdc_mag_t    peak_r;
    logic signed [ACC_W-1:0] acc_r;
    logic [CNT_W-1:0]       cnt_r;
    afdc_pkg::afdc_exp_t    exp_r;
    afdc_pkg::afdc_smp_t    est_r;
    afdc_pkg::afdc_mag_t    mag;
    afdc_pkg::afdc_mag_t    pk;
    afdc_pkg::afdc_lvl_t    lvl;
    afdc_pkg::afdc_lvl_t    lvl_now;
    afdc_pkg::afdc_lvl_t    steps;
    afdc_pkg::afdc_exp_t    exp_nxt;
    logic signed [ACC_W-1:0] smp_ext;
    logic signed [ACC_W-1:0] avg;
    logic                   above;
    logic                   grow;
    logic                   last;

    assign mag     = f_mag(smp[p]);
    assign pk      = (mag > peak_r) ? mag : peak_r;
    assign lvl     = f_lvl(pk);
    assign lvl_now = f_lvl(mag);
    // A smaller level is a louder signal
    assign above   = (lvl < i_cfg.upper_thr);
    // Whole steps above the lower threshold; zero at or below it, with no cap here
    assign steps   = (lvl < i_cfg.lower_thr) ? (i_cfg.lower_thr - lvl) : '0;
    assign exp_nxt = f_clamp(7'(min_exp) + {1'b0, steps, 1'b0});
    assign grow    = (exp_nxt > exp_r);
    assign last    = (cnt_r == '0);
    assign smp_ext = {{EXP_MAX{smp[p][SW-1]}}, smp[p]};
    assign avg     = acc_r >>> exp_r;

    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        st_r   <= afdc_pkg::AFDC_ST_START;
        peak_r <= `AFDC_PEAK_RST;
        acc_r  <= '0;
        cnt_r  <= '0;
        exp_r  <= '0;
      end
      else if (take)
      begin
        case (st_r)
          afdc_pkg::AFDC_ST_START:
          begin
            // First sample seeds peak, sum and counter
            peak_r <= mag;
            acc_r  <= smp_ext;
            cnt_r  <= f_reload(min_exp);
            exp_r  <= min_exp;
            st_r   <= afdc_pkg::AFDC_ST_RUN;
          end
          afdc_pkg::AFDC_ST_RUN:
          begin
            if (above)
            begin
              // Partial sum dropped, counter parked at the minimum
              peak_r <= mag;
              acc_r  <= '0;
              cnt_r  <= f_reload(min_exp);
              exp_r  <= min_exp;
              st_r   <= afdc_pkg::AFDC_ST_HOLD;
            end
            else if (last)
            begin
              peak_r <= mag;
              acc_r  <= smp_ext;
              cnt_r  <= f_reload(min_exp);
              exp_r  <= min_exp;
            end
            else
            begin
              peak_r <= pk;
              acc_r  <= acc_r + smp_ext;
              if (grow)
              begin
                // Extend the window so the sum still covers a full period
                cnt_r <= cnt_r - 1'b1 + f_pow2(exp_nxt) - f_pow2(exp_r);
                exp_r <= exp_nxt;
              end
              else
              begin
                cnt_r <= cnt_r - 1'b1;
              end
            end
          end
          afdc_pkg::AFDC_ST_HOLD:
          begin
            peak_r <= mag;
            cnt_r  <= f_reload(min_exp);
            exp_r  <= min_exp;
            // Fresh sum starts once the sample is back under the upper limit
            if (lvl_now >= i_cfg.upper_thr)
            begin
              acc_r <= smp_ext;
              st_r  <= afdc_pkg::AFDC_ST_RUN;
            end
            else
            begin
              acc_r <= '0;
            end
          end
          default:
          begin
            st_r <= afdc_pkg::AFDC_ST_START;
          end
        endcase
      end
    end

    // Estimate register changes only at the end of a full period
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        est_r <= `AFDC_EST_RST;
      end
      else if (take && (st_r == afdc_pkg::AFDC_ST_RUN) && !above &&
               last)
      begin
        est_r <= avg[SW-1:0];
      end
    end

    // Corrected output uses the estimate held before this sample
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        out_r[p] <= '0;
      end
      else if (take)
      begin
        out_r[p] <= f_sat_sub(smp[p], est_r);
      end
    end
  end

endmodule : afdc_top
